// >>> cic_pkg.sv
package cic_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_GLOBAL_CTRL = 16'h000B;
  localparam logic [15:0] IDX_EN_CORE = 16'h0716;
  localparam logic [15:0] IDX_EN_PERIPH_A = 16'h0717;
  localparam logic [15:0] IDX_EN_PERIPH_B = 16'h0718;
  localparam logic [15:0] IDX_FLAG_CORE = 16'h070C;
  localparam logic [15:0] IDX_PIN_SEL = 16'h0E70;
  localparam logic [15:0] IDX_SHADOW_BASE = 16'h1FE4;
  localparam int unsigned SHADOW_NUM = 8;

  // field positions
  localparam int unsigned GLOBAL_IRQ_EN_BIT = 7;
  localparam int unsigned PERIPH_GROUP_IRQ_EN_BIT = 6;
  localparam int unsigned EDGE_SEL_BIT = 0;
  localparam int unsigned EXT_EN_BIT = 0;
  localparam int unsigned EXT_FLAG_BIT = 0;
  localparam int unsigned PIN_SEL_W = 3;

  // reset values and implemented bits
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [7:0] CTRL_MASK = 8'hC1;
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [7:0] EN_CORE_MASK = 8'h31;
  localparam logic [7:0] EN_PB_MASK = 8'hE0;
  localparam logic [PIN_SEL_W-1:0] PIN_SEL_RST = 3'h0;
  // status bits kept in shadow: all but expiry (4) and sleep entry (3)
  localparam logic [7:0] STATUS_SAVE_MASK = 8'hE7;
  localparam logic [15:0] VECTOR_ADDR = 16'h0004;

  // timing
  localparam int unsigned CLK_NS = 4;
  localparam int unsigned INSTR_CYCLE_NS = 16;
  localparam int unsigned QUARTERS = INSTR_CYCLE_NS / CLK_NS;
  localparam int unsigned VECT_WAIT_INSTR = 2;

  // saved core context, one byte per field, slot order as in shadow bank
  typedef struct packed {
    logic [7:0] prog_counter_high_latch;
    logic [7:0] ptr1_hi;
    logic [7:0] ptr1_lo;
    logic [7:0] ptr0_hi;
    logic [7:0] ptr0_lo;
    logic [7:0] bank_select_reg;
    logic [7:0] status;
    logic [7:0] working_accumulator;
  } cic_ctx_type;

  // request flags raised by the peripherals (core bit 0 is unused; the external pin flag is held in cic_top)
  typedef struct packed {
    logic [7:0] core;
    logic [7:0] periph_a;
    logic [7:0] periph_b;
  } cic_flags_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_COUNT = 3'b010,
    ST_POSTWAKE = 3'b100
  } cic_state_type;

endpackage : cic_pkg

// >>> cic_sync2.sv
`timescale 1ns/1ps
module cic_sync2 #(
  parameter int unsigned W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta;

  // two flops per bit; meta feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : cic_sync2

// >>> cic_top.sv
`timescale 1ns/1ps
// Contract
// - pending requests sampled once per instruction cycle, in the first quarter only.
// - vector execution follows request by 3-5 cycles async, 3-4 sync.
// - latency is independent of one- or two-cycle current instruction.
// - external flag may set anywhere from fourth quarter to next first quarter.
// - wake branches to vector when global enable set, else resumes.
// - instruction after sleep always runs before branching to the service routine.
// - external pin edge-triggered async; select 1 rising, 0 falling, resets 1.
// - selected edge sets flag; vector needs global and external enables.
// - entry pushes return PC and copies core context into shadows.
// - exit reloads context from shadows; shadow writes are what return.
// - shadows live in bank 63, readable and writable by software.
// - global enable bit 7 allows or blocks all interrupts, resets 0.
// - peripheral group enable bit 6 gates second/third register sources, resets 0.
// - first enable register sources need only the global enable.
// - flags set regardless of enables; software clears flag before enabling.
// - first enable register: timer0 bit 5, pin change 4, external 0.
// - second enable register bits 7..0 hold eight peripheral enables, reset 0.
// - third enable register: capcmp2 bit 7, flash 6, timer1 gate 5.
// - external input taken from pin named by pin select register.
// - vectoring flushes prefetch, clears global enable, pushes PC, loads 0004h.
// - return instruction pops address, restores context, sets global enable.
// - request while globally disabled is kept and serviced once enabled.
module cic_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] ext_pins,
  input wire cic_pkg::cic_flags_type periph_flags,
  input wire cic_pkg::cic_ctx_type core_ctx,
  input wire logic core_sleeping,
  input wire logic irq_return_exec,
  output logic first_quarter_phase,
  output logic irq_vector_go,
  output logic [15:0] vector_addr,
  output logic wake_core,
  output logic ctx_restore,
  output cic_pkg::cic_ctx_type restore_ctx,
  output logic core_irq_req
);

  // register state
  logic [7:0] irq_global_control;
  logic [7:0] irq_enable_core_sources;
  logic [7:0] irq_enable_periph_a;
  logic [7:0] irq_enable_periph_b;
  logic [cic_pkg::PIN_SEL_W-1:0] ext_irq_pin_select;
  logic ext_irq_flag;
  logic [7:0] shadow [cic_pkg::SHADOW_NUM];

  // phase and sequencing state
  logic [cic_pkg::QUARTERS-1:0] quarter;
  cic_pkg::cic_state_type state;
  cic_pkg::cic_state_type next_state;
  logic [1:0] wait_cnt;
  logic [1:0] next_wait_cnt;
  logic vect_now;
  logic wake_now;

  // external pin path
  logic [7:0] pins_sync;
  logic pin_prev;
  logic pin_now;
  logic edge_hit;
  logic [2:0] pin_armed;

  // two-flop synchronisers on every candidate pin
  cic_sync2 #(
    .W(8)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(ext_pins),
    .sync_out(pins_sync)
  );

  // selected pin and its active edge
  assign pin_now = pins_sync[ext_irq_pin_select];
  assign edge_hit = pin_armed[2] & (irq_global_control[cic_pkg::EDGE_SEL_BIT] ?
                    (pin_now & ~pin_prev) : (~pin_now & pin_prev));

  // edges are ignored while the synchroniser fills after reset, so a pin
  // that idles high raises no false request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_armed <= 3'h0;
    end else begin
      pin_armed <= {pin_armed[1:0], 1'b1};
    end
  end

  // bus decode; offsets are word indices, so byte address is index times four
  logic setup_ph;
  logic wr_go;
  logic hit_ctrl;
  logic hit_en0;
  logic hit_en1;
  logic hit_en2;
  logic hit_flag;
  logic hit_psel;
  logic hit_shadow;
  logic [15:0] word_idx;
  logic [15:0] shadow_off;
  logic [2:0] shadow_slot;
  logic mapped;
  logic [7:0] rd_byte;

  assign setup_ph = psel & ~penable;
  assign wr_go = psel & penable & pready & pwrite;
  assign word_idx = {2'b00, paddr[15:2]};
  assign shadow_off = word_idx - cic_pkg::IDX_SHADOW_BASE;
  assign shadow_slot = shadow_off[2:0];
  assign hit_ctrl = (word_idx == cic_pkg::IDX_GLOBAL_CTRL);
  assign hit_en0 = (word_idx == cic_pkg::IDX_EN_CORE);
  assign hit_en1 = (word_idx == cic_pkg::IDX_EN_PERIPH_A);
  assign hit_en2 = (word_idx == cic_pkg::IDX_EN_PERIPH_B);
  assign hit_flag = (word_idx == cic_pkg::IDX_FLAG_CORE);
  assign hit_psel = (word_idx == cic_pkg::IDX_PIN_SEL);
  assign hit_shadow = (word_idx >= cic_pkg::IDX_SHADOW_BASE) &&
                      (shadow_off < 16'(cic_pkg::SHADOW_NUM));
  assign mapped = (paddr[1:0] == 2'b00) & (hit_ctrl | hit_en0 | hit_en1 | hit_en2 |
                  hit_flag | hit_psel | hit_shadow);

  // flag view: external flag held here, the others come from peripherals
  logic [7:0] flags_core;

  assign flags_core = {periph_flags.core[7:1], ext_irq_flag};

  // read mux
  assign rd_byte = hit_ctrl ? irq_global_control :
                   hit_en0 ? irq_enable_core_sources :
                   hit_en1 ? irq_enable_periph_a :
                   hit_en2 ? irq_enable_periph_b :
                   hit_flag ? flags_core :
                   hit_psel ? {5'h00, ext_irq_pin_select} :
                   hit_shadow ? shadow[shadow_slot] : 8'h00;

  // request forming
  logic core_any;
  logic periph_any;
  logic enabled_any;
  logic global_irq_en;
  logic pending;

  assign global_irq_en = irq_global_control[cic_pkg::GLOBAL_IRQ_EN_BIT];
  assign core_any = |(irq_enable_core_sources & flags_core);
  assign periph_any = (|(irq_enable_periph_a & periph_flags.periph_a)) |
                      (|(irq_enable_periph_b & periph_flags.periph_b));
  assign enabled_any = core_any |
                       (irq_global_control[cic_pkg::PERIPH_GROUP_IRQ_EN_BIT] &
                        periph_any);
  assign pending = global_irq_en & enabled_any;

  // one-hot quarter phase; the first quarter is bit 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quarter <= 4'h1;
    end else begin
      quarter <= {quarter[cic_pkg::QUARTERS-2:0], quarter[cic_pkg::QUARTERS-1]};
    end
  end

  assign first_quarter_phase = quarter[0];

  // sequencer acts only in the first quarter, so what the current
  // instruction is (one or two cycles) never shifts the vector point
  always_comb begin
    next_state = state;
    next_wait_cnt = wait_cnt;
    vect_now = 1'b0;
    wake_now = 1'b0;
    if (quarter[0]) begin
      unique case (state)
        cic_pkg::ST_IDLE: begin
          if (core_sleeping & enabled_any) begin
            wake_now = 1'b1;
            if (global_irq_en) begin
              next_state = cic_pkg::ST_POSTWAKE;
            end
          end else if (pending) begin
            next_state = cic_pkg::ST_COUNT;
            next_wait_cnt = 2'h0;
          end
        end
        cic_pkg::ST_POSTWAKE: begin
          // the instruction after sleep has now executed
          next_state = cic_pkg::ST_COUNT;
          next_wait_cnt = 2'h0;
        end
        cic_pkg::ST_COUNT: begin
          if (!global_irq_en) begin
            // software masked meanwhile; the flag keeps the request
            next_state = cic_pkg::ST_IDLE;
          end else if (wait_cnt == 2'(cic_pkg::VECT_WAIT_INSTR - 1)) begin
            vect_now = 1'b1;
            next_state = cic_pkg::ST_IDLE;
          end else begin
            next_wait_cnt = wait_cnt + 2'h1;
          end
        end
      endcase
    end
  end

  // sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= cic_pkg::ST_IDLE;
      wait_cnt <= 2'h0;
    end else begin
      state <= next_state;
      wait_cnt <= next_wait_cnt;
    end
  end

  // core-facing strobes, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_vector_go <= 1'b0;
      vector_addr <= 16'h0000;
      wake_core <= 1'b0;
      ctx_restore <= 1'b0;
      core_irq_req <= 1'b0;
    end else begin
      irq_vector_go <= vect_now;
      vector_addr <= cic_pkg::VECTOR_ADDR;
      wake_core <= wake_now;
      ctx_restore <= irq_return_exec;
      core_irq_req <= pending;
    end
  end

  // restore values are taken from shadows, never from live copies
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restore_ctx <= '0;
    end else if (irq_return_exec) begin
      restore_ctx <= {shadow[7], shadow[6], shadow[5], shadow[4],
                      shadow[3], shadow[2], shadow[1], shadow[0]};
    end
  end

  // shadow bank: hardware capture on entry beats a software write
  logic [63:0] cap_ctx;

  assign cap_ctx = {core_ctx[63:16], core_ctx.status & cic_pkg::STATUS_SAVE_MASK,
                    core_ctx.working_accumulator};

  genvar gi;
  generate
    for (gi = 0; gi < cic_pkg::SHADOW_NUM; gi++) begin : g_shadow
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          shadow[gi] <= 8'h00;
        end else if (vect_now) begin
          shadow[gi] <= cap_ctx[gi*8 +: 8];
        end else if (wr_go & hit_shadow & (shadow_slot == 3'(gi))) begin
          shadow[gi] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // global control: vector clears enable, return sets it, else software
  logic [7:0] next_ctrl;

  assign next_ctrl = (wr_go & hit_ctrl) ? (pwdata[7:0] & cic_pkg::CTRL_MASK) :
                     irq_global_control;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_global_control <= cic_pkg::CTRL_RST;
    end else begin
      irq_global_control <= next_ctrl;
      if (vect_now) begin
        irq_global_control[cic_pkg::GLOBAL_IRQ_EN_BIT] <= 1'b0;
      end else if (irq_return_exec) begin
        irq_global_control[cic_pkg::GLOBAL_IRQ_EN_BIT] <= 1'b1;
      end
    end
  end

  // enable registers and pin select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_core_sources <= cic_pkg::EN_RST;
      irq_enable_periph_a <= cic_pkg::EN_RST;
      irq_enable_periph_b <= cic_pkg::EN_RST;
      ext_irq_pin_select <= cic_pkg::PIN_SEL_RST;
    end else if (wr_go) begin
      if (hit_en0) begin
        irq_enable_core_sources <= pwdata[7:0] & cic_pkg::EN_CORE_MASK;
      end
      if (hit_en1) begin
        irq_enable_periph_a <= pwdata[7:0];
      end
      if (hit_en2) begin
        irq_enable_periph_b <= pwdata[7:0] & cic_pkg::EN_PB_MASK;
      end
      if (hit_psel) begin
        ext_irq_pin_select <= pwdata[cic_pkg::PIN_SEL_W-1:0];
      end
    end
  end

  // external flag: an edge in the clearing cycle wins, and no enable
  // gates the set, so software may poll it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq_flag <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= pin_now;
      if (edge_hit) begin
        ext_irq_flag <= 1'b1;
      end else if (wr_go & hit_flag) begin
        ext_irq_flag <= pwdata[cic_pkg::EXT_FLAG_BIT];
      end
    end
  end

  // apb answer: ready in the first access cycle, data latched at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      if (setup_ph) begin
        prdata <= {24'h000000, mapped ? rd_byte : 8'h00};
        pslverr <= ~mapped;
      end
    end
  end

endmodule : cic_top

// >>> cic_core_model.sv
`timescale 1ns/1ps
// core stand-in: scribbles the live context inside the routine, then returns
module cic_core_model #(
  parameter int ROUTINE_LEN = 24,
  parameter logic [63:0] CTX_RST = 64'h0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_vector_go,
  input wire logic ctx_restore,
  input wire cic_pkg::cic_ctx_type restore_ctx,
  output cic_pkg::cic_ctx_type core_ctx,
  output logic irq_return_exec
);
  int cnt;
  // live edits made in the routine must not survive the return
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      core_ctx <= CTX_RST;
      irq_return_exec <= 1'b0;
    end else begin
      cnt <= irq_vector_go ? ROUTINE_LEN : (cnt > 0 ? cnt - 1 : 0);
      irq_return_exec <= (cnt == 1);
      if (irq_vector_go) begin
        core_ctx <= ~core_ctx;
      end else if (ctx_restore) begin
        core_ctx <= restore_ctx;
      end
    end
  end
endmodule : cic_core_model

// >>> cic_top_properties.sv
`timescale 1ns/1ps
module cic_top_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic core_sleeping,
  input wire logic irq_return_exec,
  input wire logic first_quarter_phase,
  input wire logic irq_vector_go,
  input wire logic [15:0] vector_addr,
  input wire logic wake_core,
  input wire logic ctx_restore,
  input wire logic core_irq_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // one sampling slot in every four clocks
  phase_ring_a: assert property (first_quarter_phase |=>
    !first_quarter_phase [*3] ##1 first_quarter_phase) else $error("quarter ring broken");
  vec_from_phase_a: assert property ($rose(irq_vector_go) |->
    $past(first_quarter_phase)) else $error("vector not launched in first quarter");
  vec_addr_a: assert property (irq_vector_go |-> vector_addr == 16'h0004)
    else $error("wrong vector address");
  vec_disable_a: assert property (irq_vector_go |-> core_irq_req
    ##1 (!core_irq_req && !irq_vector_go)) else $error("enable not dropped on vector");
  req_lat_a: assert property ($rose(core_irq_req) && !core_sleeping
    |-> ##[1:16] irq_vector_go) else $error("vector latency too long");
  ret_restore_a: assert property (irq_return_exec |=> ctx_restore)
    else $error("no restore after return");
  restore_cause_a: assert property (ctx_restore |-> $past(irq_return_exec))
    else $error("restore without return");
  wake_sleep_a: assert property (wake_core |-> $past(core_sleeping) ##1 !wake_core)
    else $error("bad wake pulse");
  wake_gap_a: assert property ($rose(wake_core) |->
    !irq_vector_go [*8] ##1 !irq_vector_go) else $error("vector before post-sleep instruction");
  apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("bus answer late");
endmodule : cic_top_properties

bind cic_top cic_top_properties chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .core_sleeping(core_sleeping),
  .irq_return_exec(irq_return_exec),
  .first_quarter_phase(first_quarter_phase),
  .irq_vector_go(irq_vector_go),
  .vector_addr(vector_addr),
  .wake_core(wake_core),
  .ctx_restore(ctx_restore),
  .core_irq_req(core_irq_req)
);

// >>> cic_top_bench.sv
`timescale 1ns/1ps
module cic_top_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, core_sleeping;
  logic irq_return_exec, first_quarter_phase, irq_vector_go, wake_core, ctx_restore;
  logic core_irq_req;
  logic [15:0] paddr, vector_addr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] ext_pins;
  cic_pkg::cic_flags_type periph_flags;
  cic_pkg::cic_ctx_type core_ctx, restore_ctx;
  int errors, cmp_count, cyc, n;
  localparam logic [63:0] CTX0 = 64'h8877_6655_4433_9F11;
  localparam logic [63:0] MK = 64'hFFFF_FFFF_FFFF_E7FF;

  cic_top dut (.*);
  cic_core_model #(.ROUTINE_LEN(24), .CTX_RST(CTX0)) model (.*);

  // free-running clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one bus transfer; the request holds until pready is seen high
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx[13:0], 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // bounded wait for vector (0), wake (1) or restore (2); n = lim if never seen
  task automatic wt(input int which, input int lim);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (n < lim && (which == 0 ? irq_vector_go :
               which == 1 ? wake_core : ctx_restore) !== 1'b1);
  endtask : wt

  task automatic t_regs;
    logic [15:0] idx [4];
    logic [7:0] msk [4];
    idx = '{cic_pkg::IDX_GLOBAL_CTRL, cic_pkg::IDX_EN_CORE, cic_pkg::IDX_EN_PERIPH_A,
            cic_pkg::IDX_EN_PERIPH_B};
    msk = '{cic_pkg::CTRL_MASK, cic_pkg::EN_CORE_MASK, 8'hFF, cic_pkg::EN_PB_MASK};
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, idx[i], 8'h00);
      chk(rd, i == 0 ? cic_pkg::CTRL_RST : cic_pkg::EN_RST);
      apb(1'b1, idx[i], 8'hFF);
      apb(1'b0, idx[i], 8'h00);
      chk(rd, msk[i]);
      chk(pslverr, 1'b0);
      apb(1'b1, idx[i], i == 0 ? cic_pkg::CTRL_RST : 8'h00);
    end
    apb(1'b0, 16'h0001, 8'h00);
    chk(pslverr, 1'b1);
    $display("test regs done");
  endtask : t_regs

  task automatic t_core;
    apb(1'b1, cic_pkg::IDX_EN_CORE, 8'h20);
    periph_flags.core[5] <= 1'b1;
    wt(0, 24);
    chk(n, 24);
    apb(1'b1, cic_pkg::IDX_GLOBAL_CTRL, 8'h81);
    wt(0, 24);
    chk(n < 24, 1'b1);
    apb(1'b1, cic_pkg::IDX_SHADOW_BASE, 8'h5A);
    periph_flags.core[5] <= 1'b0;
    wt(2, 40);
    chk(restore_ctx & MK, {CTX0[63:8], 8'h5A} & MK);
    apb(1'b0, cic_pkg::IDX_SHADOW_BASE + 16'h0001, 8'h00);
    chk(rd, CTX0[15:8] & cic_pkg::STATUS_SAVE_MASK);
    chk(core_ctx & MK, {CTX0[63:8], 8'h5A} & MK);
    apb(1'b0, cic_pkg::IDX_GLOBAL_CTRL, 8'h00);
    chk(rd[7], 1'b1);
    $display("test core source done");
  endtask : t_core

  task automatic t_periph;
    apb(1'b1, cic_pkg::IDX_EN_PERIPH_A, 8'h80);
    periph_flags.periph_a[7] <= 1'b1;
    wt(0, 24);
    chk(n, 24);
    apb(1'b1, cic_pkg::IDX_GLOBAL_CTRL, 8'hC1);
    wt(0, 24);
    chk(n < 24, 1'b1);
    periph_flags.periph_a[7] <= 1'b0;
    wt(2, 40);
    chk(n < 40, 1'b1);
    $display("test group enable done");
  endtask : t_periph

  task automatic t_ext;
    apb(1'b1, cic_pkg::IDX_PIN_SEL, 8'h03);
    apb(1'b1, cic_pkg::IDX_GLOBAL_CTRL, 8'h40);
    apb(1'b1, cic_pkg::IDX_FLAG_CORE, 8'h00);
    ext_pins <= 8'h08;
    repeat (2 * cic_pkg::QUARTERS) @(posedge pclk);
    apb(1'b0, cic_pkg::IDX_FLAG_CORE, 8'h00);
    chk(rd[0], 1'b0);
    ext_pins <= 8'h00;
    repeat (2 * cic_pkg::QUARTERS) @(posedge pclk);
    apb(1'b0, cic_pkg::IDX_FLAG_CORE, 8'h00);
    chk(rd[0], 1'b1);
    apb(1'b1, cic_pkg::IDX_EN_CORE, 8'h01);
    apb(1'b1, cic_pkg::IDX_GLOBAL_CTRL, 8'h80);
    wt(0, 24);
    chk(n < 24, 1'b1);
    apb(1'b1, cic_pkg::IDX_FLAG_CORE, 8'h00);
    wt(2, 40);
    $display("test external pin done");
  endtask : t_ext

  task automatic t_sleep;
    apb(1'b1, cic_pkg::IDX_GLOBAL_CTRL, 8'h00);
    apb(1'b1, cic_pkg::IDX_EN_CORE, 8'h20);
    core_sleeping <= 1'b1;
    periph_flags.core[5] <= 1'b1;
    wt(1, 24);
    chk(n < 24, 1'b1);
    core_sleeping <= 1'b0;
    wt(0, 24);
    chk(n, 24);
    periph_flags.core[5] <= 1'b0;
    apb(1'b1, cic_pkg::IDX_GLOBAL_CTRL, 8'h80);
    core_sleeping <= 1'b1;
    periph_flags.core[5] <= 1'b1;
    wt(1, 24);
    core_sleeping <= 1'b0;
    wt(0, 24);
    chk(n >= cic_pkg::QUARTERS && n < 24, 1'b1);
    periph_flags.core[5] <= 1'b0;
    wt(2, 40);
    $display("test sleep done");
  endtask : t_sleep

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // hang guard, well beyond the few hundred cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      $display("Error %0t: run timed out", $time);
      results();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    ext_pins = 8'h04;
    periph_flags = '0;
    core_sleeping = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_core();
    t_periph();
    t_ext();
    t_sleep();
    results();
  end
endmodule : cic_top_bench
